//--- design/maio_pkg.sv
// Shared constants and types for the motion axis I/O logic.
package maio_pkg;

  // ==========
  // Clock and timing
  // ==========
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BAUD_SLOW = 19200;
  localparam int unsigned BAUD_FAST = 115200;
  localparam logic [15:0] BAUD_DIV_SLOW = 16'(CLK_HZ / BAUD_SLOW);
  localparam logic [15:0] BAUD_DIV_FAST = 16'(CLK_HZ / BAUD_FAST);
  localparam int unsigned QUAD_MAX_RATE = 15_000_000;
  // Cycles between two quadrature states at the fastest rate.
  localparam int unsigned QUAD_MIN_CYC = CLK_HZ / QUAD_MAX_RATE;

  // ==========
  // Widths and reset values
  // ==========
  localparam int unsigned POS_W = 32;
  localparam int unsigned CMD_W = 16;
  localparam int unsigned OUT_W = 4;
  localparam int unsigned IN_W = 8;
  localparam logic [OUT_W-1:0] OUT_RST = 4'h0;
  localparam logic [CMD_W-1:0] CMD_RST = 16'h0000;
  // Index of general input that doubles as latch A trigger.
  localparam int unsigned LATCH_IN_IDX = 0;

  // ==========
  // Motor type and homing state encoding
  // ==========
  typedef enum logic [2:0] {
    MAIO_MT_SERVO = 3'h0,
    MAIO_MT_STEP_P2 = 3'h1,
    MAIO_MT_STEP_N2 = 3'h2,
    MAIO_MT_STEP_P25 = 3'h3,
    MAIO_MT_STEP_N25 = 3'h4
  } maio_mt_t;

  typedef enum logic [3:0] {
    MAIO_HS_IDLE = 4'b0001,
    MAIO_HS_ARMED = 4'b0010,
    MAIO_HS_SLEW = 4'b0100,
    MAIO_HS_STOP = 4'b1000
  } maio_home_t;

endpackage

//--- design/maio_sync.sv
// Two-flop synchroniser for a vector of level inputs.
`timescale 1ns/100ps
module maio_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= '0;
      q_o <= '0;
    end else begin
      meta_ff <= d_i;
      q_o <= meta_ff;
    end
  end
endmodule

//--- design/maio_quad.sv
// Quadrature or pulse/direction decoder with position counter.
`timescale 1ns/100ps
module maio_quad #(
  parameter int unsigned W = 32
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic pulse_dir_i,
  input wire logic a_i,
  input wire logic b_i,
  input wire logic clear_i,
  output logic [W-1:0] pos_o
);
  logic a_ff;
  logic b_ff;
  logic step;
  logic up;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_ff <= 1'b0;
      b_ff <= 1'b0;
    end else begin
      a_ff <= a_i;
      b_ff <= b_i;
    end
  end

  // Every edge of either channel is one count, giving four per cycle; direction
  // from which channel leads. In pulse mode only rising A counts, B sets sense.
  always_comb begin
    if (pulse_dir_i) begin
      step = a_i & ~a_ff;
      up = b_i;
    end else begin
      step = (a_i ^ a_ff) | (b_i ^ b_ff);
      up = (a_i ^ b_ff);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pos_o <= '0;
    end else if (clear_i) begin
      pos_o <= '0;
    end else if (enable_i && step) begin
      pos_o <= up ? pos_o + W'(1) : pos_o - W'(1);
    end
  end
endmodule

//--- design/maio_axis.sv
// Single-axis motion I/O logic: command, stepper, encoders, switches, latch.
`timescale 1ns/100ps
module maio_axis
  import maio_pkg::*;
#(
  parameter int unsigned POS_WIDTH = maio_pkg::POS_W
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic baud_jumper_i,
  output logic [15:0] baud_divisor_o,
  input wire logic sample_tick_i,
  input wire logic motor_on_i,
  input wire maio_pkg::maio_mt_t motor_type_setting_i,
  input wire logic step_active_high_i,
  input wire logic [15:0] step_half_period_i,
  input wire logic step_request_i,
  input wire logic step_forward_i,
  input wire logic [maio_pkg::CMD_W-1:0] servo_result_i,
  input wire logic [maio_pkg::CMD_W-1:0] idle_command_level_i,
  output logic [maio_pkg::CMD_W-1:0] motor_command_o,
  input wire logic shutdown_on_error_i,
  input wire logic hardware_lockout_i,
  output logic amp_enable_o,
  output logic internal_amp_off_o,
  output logic step_pulse_pin_o,
  output logic step_direction_pin_o,
  output logic step_busy_o,
  input wire logic [POS_WIDTH-1:0] commanded_pos_i,
  input wire logic [POS_WIDTH-1:0] position_fault_limit_i,
  output logic error_n_o,
  input wire logic output_bit_set_i,
  input wire logic output_bit_clear_i,
  input wire logic [1:0] output_bit_index_i,
  input wire logic output_port_write_i,
  input wire logic [maio_pkg::OUT_W-1:0] output_port_value_i,
  output logic [maio_pkg::OUT_W-1:0] general_out_o,
  input wire logic encoder_pulse_dir_i,
  input wire logic motor_encoder_a_i,
  input wire logic motor_encoder_b_i,
  input wire logic motor_encoder_index_i,
  input wire logic load_encoder_a_i,
  input wire logic load_encoder_b_i,
  output logic [POS_WIDTH-1:0] motor_position_o,
  output logic [POS_WIDTH-1:0] load_position_o,
  input wire logic abort_n_i,
  input wire logic reset_n_i,
  output logic motion_abort_o,
  output logic program_abort_o,
  output logic processor_reset_o,
  input wire logic forward_limit_i,
  input wire logic reverse_limit_i,
  input wire logic home_switch_i,
  input wire logic [2:0] switch_polarity_select_i,
  output logic forward_blocked_o,
  output logic reverse_blocked_o,
  output logic limit_handler_routine_o,
  input wire logic homing_command_i,
  input wire logic edge_search_i,
  input wire logic find_index_i,
  input wire logic begin_motion_i,
  output logic slew_o,
  output logic decel_stop_o,
  output logic home_defined_o,
  input wire logic [maio_pkg::IN_W-1:0] general_in_i,
  output logic [maio_pkg::IN_W-1:0] general_in_o,
  input wire logic latch_enable_i,
  input wire logic latch_arm_i,
  output logic latch_armed_o,
  output logic latch_captured_o,
  output logic [POS_WIDTH-1:0] latch_position_o
);
  import maio_pkg::*;

  // ==========
  // Reset release
  // ==========
  logic rst_meta_ff;
  logic rst_n;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n <= rst_meta_ff;
    end
  end

  // ==========
  // Input synchronisers
  // ==========
  logic [IN_W+5:0] sync_raw;
  logic [IN_W+5:0] sync_q;
  assign sync_raw = {general_in_i, abort_n_i, reset_n_i, forward_limit_i,
                     reverse_limit_i, home_switch_i, motor_encoder_index_i};
  maio_sync #(.W(IN_W + 6)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i(sync_raw),
    .q_o(sync_q)
  );

  logic abort_n_s;
  logic reset_n_s;
  logic fls_act;
  logic rls_act;
  logic home_act;
  logic index_s;
  logic [IN_W-1:0] gin_s;
  assign gin_s = sync_q[IN_W+5:6];
  assign abort_n_s = sync_q[5];
  assign reset_n_s = sync_q[4];
  assign fls_act = sync_q[3] ^ ~switch_polarity_select_i[0];
  assign rls_act = sync_q[2] ^ ~switch_polarity_select_i[1];
  assign home_act = sync_q[1] ^ ~switch_polarity_select_i[2];
  assign index_s = sync_q[0];
  assign general_in_o = gin_s;

  // ==========
  // Baud selection
  // ==========
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      baud_divisor_o <= BAUD_DIV_FAST;
    end else begin
      baud_divisor_o <= baud_jumper_i ? BAUD_DIV_SLOW : BAUD_DIV_FAST;
    end
  end

  // ==========
  // Abort and reset
  // ==========
  // Abort acts on the synchronised level with no ramp; the supervisor sees it
  // as a stop-now request and terminates the program in the same cycle.
  assign motion_abort_o = ~abort_n_s;
  assign program_abort_o = ~abort_n_s;
  // The reset pin asks the supervisor to reboot and reload saved parameters.
  assign processor_reset_o = ~reset_n_s;

  // ==========================================================================
  // Motor command
  // ==========================================================================
  logic stepper;
  assign stepper = (motor_type_setting_i != MAIO_MT_SERVO);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      motor_command_o <= CMD_RST;
    end else if (!motor_on_i) begin
      motor_command_o <= idle_command_level_i;
    end else if (sample_tick_i && !stepper) begin
      motor_command_o <= servo_result_i;
    end
  end

  // ==========================================================================
  // Amplifier enable and lockout
  // ==========================================================================
  logic err_over;
  // Lockout bypasses every register so the amplifier drops even if the
  // clocked logic were stuck.
  assign internal_amp_off_o = hardware_lockout_i;
  assign amp_enable_o = abort_n_s & ~(shutdown_on_error_i & err_over) & ~hardware_lockout_i;

  // ==========================================================================
  // Position error
  // ==========================================================================
  logic [POS_WIDTH-1:0] pos_err;
  logic [POS_WIDTH-1:0] pos_err_mag;
  assign pos_err = commanded_pos_i - motor_position_o;
  assign pos_err_mag = pos_err[POS_WIDTH-1] ? (~pos_err + POS_WIDTH'(1)) : pos_err;
  assign err_over = pos_err_mag > position_fault_limit_i;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      error_n_o <= 1'b1;
    end else begin
      error_n_o <= ~err_over;
    end
  end

  // ==========================================================================
  // Step and direction generator
  // ==========================================================================
  logic [15:0] step_cnt_ff;
  logic [1:0] step_phase_ff;
  logic step_level_ff;
  logic dir_ff;
  logic step_allowed;
  assign step_allowed = step_forward_i ? ~forward_blocked_o : ~reverse_blocked_o;

  // Each step is active for step_half_period_i cycles, then idle for at least as many cycles before the next.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt_ff <= 16'h0000;
      step_phase_ff <= 2'h0;
      step_level_ff <= 1'b0;
      dir_ff <= 1'b0;
    end else if (!stepper || motion_abort_o) begin
      step_cnt_ff <= 16'h0000;
      step_phase_ff <= 2'h0;
      step_level_ff <= 1'b0;
    end else if (step_phase_ff == 2'h0) begin
      if (step_request_i && step_allowed) begin
        dir_ff <= step_forward_i;
        step_level_ff <= 1'b1;
        step_phase_ff <= 2'h1;
        step_cnt_ff <= step_half_period_i;
      end
    end else if (step_cnt_ff > 16'h0001) begin
      step_cnt_ff <= step_cnt_ff - 16'h0001;
    end else if (step_phase_ff == 2'h1) begin
      step_level_ff <= 1'b0;
      step_phase_ff <= 2'h2;
      step_cnt_ff <= step_half_period_i;
    end else begin
      step_phase_ff <= 2'h0;
    end
  end

  assign step_busy_o = step_phase_ff != 2'h0;
  assign step_pulse_pin_o = stepper & (step_level_ff ~^ step_active_high_i);
  assign step_direction_pin_o = stepper & dir_ff;

  // ==========================================================================
  // General outputs
  // ==========================================================================
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      general_out_o <= OUT_RST;
    end else if (output_port_write_i) begin
      general_out_o <= output_port_value_i;
    end else if (output_bit_set_i) begin
      general_out_o[output_bit_index_i] <= 1'b1;
    end else if (output_bit_clear_i) begin
      general_out_o[output_bit_index_i] <= 1'b0;
    end
  end

  // ==========================================================================
  // Encoders
  // ==========================================================================
  // Only the true channels are used; complement inputs are not required.
  // Inputs are taken as synchronous, so a 100 MHz sample covers 15M states/s.
  logic home_clear;
  maio_quad #(.W(POS_WIDTH)) u_motor_enc (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .enable_i(1'b1),
    .pulse_dir_i(encoder_pulse_dir_i),
    .a_i(motor_encoder_a_i),
    .b_i(motor_encoder_b_i),
    .clear_i(home_clear),
    .pos_o(motor_position_o)
  );

  maio_quad #(.W(POS_WIDTH)) u_load_enc (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .enable_i(~stepper),
    .pulse_dir_i(encoder_pulse_dir_i),
    .a_i(load_encoder_a_i),
    .b_i(load_encoder_b_i),
    .clear_i(stepper),
    .pos_o(load_position_o)
  );

  // ==========================================================================
  // Limits
  // ==========================================================================
  logic fls_prev_ff;
  logic rls_prev_ff;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fls_prev_ff <= 1'b0;
      rls_prev_ff <= 1'b0;
      limit_handler_routine_o <= 1'b0;
    end else begin
      fls_prev_ff <= fls_act;
      rls_prev_ff <= rls_act;
      limit_handler_routine_o <= (fls_act & ~fls_prev_ff) | (rls_act & ~rls_prev_ff);
    end
  end
  assign forward_blocked_o = fls_act;
  assign reverse_blocked_o = rls_act;

  // ==========================================================================
  // Homing and find index
  // ==========================================================================
  maio_home_t home_ff;
  logic home_prev_ff;
  logic index_prev_ff;
  logic find_index_ff;
  logic index_rise;
  assign index_rise = index_s & ~index_prev_ff;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      home_ff <= MAIO_HS_IDLE;
      home_prev_ff <= 1'b0;
      index_prev_ff <= 1'b0;
      find_index_ff <= 1'b0;
    end else begin
      home_prev_ff <= home_act;
      index_prev_ff <= index_s;
      if (motion_abort_o) begin
        home_ff <= MAIO_HS_IDLE;
        find_index_ff <= 1'b0;
      end else begin
        if (find_index_i) begin
          find_index_ff <= 1'b1;
        end else if (index_rise) begin
          find_index_ff <= 1'b0;
        end
        case (home_ff)
          MAIO_HS_IDLE: begin
            if (homing_command_i || edge_search_i) begin
              home_ff <= MAIO_HS_ARMED;
            end
          end
          MAIO_HS_ARMED: begin
            if (begin_motion_i) begin
              home_ff <= MAIO_HS_SLEW;
            end
          end
          MAIO_HS_SLEW: begin
            if (home_act != home_prev_ff) begin
              home_ff <= MAIO_HS_STOP;
            end
          end
          MAIO_HS_STOP: begin
            home_ff <= MAIO_HS_IDLE;
          end
          default: begin
            home_ff <= MAIO_HS_IDLE;
          end
        endcase
      end
    end
  end

  assign slew_o = home_ff == MAIO_HS_SLEW;
  assign decel_stop_o = home_ff == MAIO_HS_STOP;
  assign home_clear = index_rise & (find_index_ff | slew_o);
  assign home_defined_o = home_clear;

  // ==========================================================================
  // Position latch
  // ==========================================================================
  logic latch_prev_ff;
  logic latch_edge;
  assign latch_edge = latch_enable_i & gin_s[LATCH_IN_IDX] & ~latch_prev_ff;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      latch_prev_ff <= 1'b0;
      latch_armed_o <= 1'b0;
      latch_captured_o <= 1'b0;
      latch_position_o <= '0;
    end else begin
      latch_prev_ff <= gin_s[LATCH_IN_IDX];
      if (latch_armed_o && latch_edge) begin
        latch_position_o <= motor_position_o;
        latch_armed_o <= 1'b0;
        latch_captured_o <= 1'b1;
      end else if (latch_arm_i) begin
        latch_armed_o <= 1'b1;
        latch_captured_o <= 1'b0;
      end
    end
  end

endmodule

//--- bench/maio_encoder_model.sv
// Behavioural quadrature encoder standing at the far side of the axis.
`timescale 1ns/100ps
module maio_encoder_model (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic fwd_i,
  output logic a_o,
  output logic b_o
);
  import maio_pkg::*;
  // ==========
  // State stepping
  // ==========
  logic [1:0] ph_ff = 2'h0;
  int gap_ff = 0;
  // One state every QUAD_MIN_CYC cycles is the fastest legal rate.
  always_ff @(posedge clk_i) begin
    if (run_i && gap_ff == QUAD_MIN_CYC - 1) begin
      ph_ff <= fwd_i ? ph_ff + 2'h1 : ph_ff - 2'h1;
      gap_ff <= 0;
    end else begin
      gap_ff <= run_i ? gap_ff + 1 : 0;
    end
  end
  // Gray-coded channels; the complementary lines are optional and left out.
  assign a_o = ph_ff[1];
  assign b_o = ph_ff[1] ^ ph_ff[0];
endmodule

//--- bench/maio_axis_monitor.sv
// Concurrent checks on the ports of the motion axis I/O logic.
`timescale 1ns/100ps
module maio_axis_monitor #(
  parameter int unsigned POS_WIDTH = 32
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic baud_jumper_i,
  input wire logic [15:0] baud_divisor_o,
  input wire logic sample_tick_i,
  input wire logic motor_on_i,
  input wire maio_pkg::maio_mt_t motor_type_setting_i,
  input wire logic [15:0] servo_result_i,
  input wire logic [15:0] idle_command_level_i,
  input wire logic [15:0] motor_command_o,
  input wire logic hardware_lockout_i,
  input wire logic amp_enable_o,
  input wire logic internal_amp_off_o,
  input wire logic step_active_high_i,
  input wire logic [15:0] step_half_period_i,
  input wire logic step_pulse_pin_o,
  input wire logic step_busy_o,
  input wire logic output_bit_set_i,
  input wire logic [1:0] output_bit_index_i,
  input wire logic output_port_write_i,
  input wire logic [3:0] output_port_value_i,
  input wire logic [3:0] general_out_o,
  input wire logic abort_n_i,
  input wire logic reset_n_i,
  input wire logic motion_abort_o,
  input wire logic program_abort_o,
  input wire logic processor_reset_o,
  input wire logic forward_limit_i,
  input wire logic [2:0] switch_polarity_select_i,
  input wire logic forward_blocked_o,
  input wire logic latch_armed_o,
  input wire logic latch_captured_o,
  input wire logic [POS_WIDTH-1:0] latch_position_o,
  input wire logic [POS_WIDTH-1:0] motor_position_o
);
  import maio_pkg::*;
  // ==========
  // Helpers
  // ==========
  logic [2:0] up_ff;
  logic [15:0] hi_ff;
  wire logic act = step_pulse_pin_o == step_active_high_i;
  // Internal reset and synchronisers settle in a few edges.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      up_ff <= 3'h0;
    end else if (up_ff != 3'h7) begin
      up_ff <= up_ff + 3'h1;
    end
  end
  // Counting only while busy hides polarity changes at idle.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hi_ff <= 16'h0;
    end else begin
      hi_ff <= (act && step_busy_o) ? hi_ff + 16'h1 : 16'h0;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i || up_ff != 3'h7);
  // ==========
  // Assertions
  // ==========
  baud_slow_a: assert property (baud_jumper_i [*3] |-> baud_divisor_o == BAUD_DIV_SLOW)
    else $error("baud divisor wrong");
  cmd_refresh_a: assert property (motor_on_i && sample_tick_i && motor_type_setting_i == MAIO_MT_SERVO ##1 motor_on_i
    |-> motor_command_o == $past(servo_result_i)) else $error("command not refreshed");
  cmd_idle_a: assert property (!motor_on_i [*2] |-> motor_command_o == $past(idle_command_level_i))
    else $error("command not idle");
  amp_abort_a: assert property (!abort_n_i [*3] |-> !amp_enable_o && motion_abort_o && program_abort_o)
    else $error("abort ignored");
  amp_lockout_a: assert property (hardware_lockout_i |-> !amp_enable_o && internal_amp_off_o)
    else $error("lockout ignored");
  step_width_a: assert property ($fell(act) && step_busy_o |-> hi_ff == step_half_period_i)
    else $error("step width wrong");
  gpo_write_a: assert property (output_port_write_i |=> general_out_o == $past(output_port_value_i))
    else $error("port write not applied");
  gpo_set_a: assert property (output_bit_set_i && !output_port_write_i |=> general_out_o[$past(output_bit_index_i)])
    else $error("bit set not applied");
  reset_in_a: assert property (!reset_n_i [*3] |-> processor_reset_o)
    else $error("reset ignored");
  fwd_limit_a: assert property ((forward_limit_i == switch_polarity_select_i[0]) [*3] |-> forward_blocked_o)
    else $error("limit ignored");
  latch_hold_a: assert property ($rose(latch_captured_o) |-> !latch_armed_o
    && latch_position_o == $past(motor_position_o)) else $error("latch capture wrong");
endmodule
bind maio_axis maio_axis_monitor #(.POS_WIDTH(POS_WIDTH)) u_mon (.*);

//--- bench/test_motion_axis_io_logic.sv
// Self-checking testbench for the motion axis I/O logic.
`timescale 1ns/100ps
module test_motion_axis_io_logic;
  import maio_pkg::*;
  logic clk_i = 1'h0, nrst_i = 1'h0, baud_jumper_i = 1'h0, sample_tick_i = 1'h0, motor_on_i = 1'h0;
  maio_mt_t motor_type_setting_i = MAIO_MT_SERVO;
  logic step_active_high_i = 1'h1, step_request_i = 1'h0, step_forward_i = 1'h1, shutdown_on_error_i = 1'h0;
  logic hardware_lockout_i = 1'h0, output_bit_set_i = 1'h0, output_bit_clear_i = 1'h0, output_port_write_i = 1'h0;
  logic [15:0] step_half_period_i = 16'h3, servo_result_i = 16'h1234, idle_command_level_i = 16'h8000;
  logic [15:0] baud_divisor_o, motor_command_o;
  logic [31:0] commanded_pos_i = 32'h0, position_fault_limit_i = 32'h10, p;
  logic [31:0] motor_position_o, load_position_o, latch_position_o;
  logic [1:0] output_bit_index_i = 2'h0, d;
  logic [3:0] output_port_value_i = 4'h0, general_out_o;
  logic [7:0] general_in_i = 8'h0, general_in_o;
  logic encoder_pulse_dir_i = 1'h0, motor_encoder_a_i, motor_encoder_b_i, motor_encoder_index_i = 1'h0;
  logic load_encoder_a_i, load_encoder_b_i, abort_n_i = 1'h1, reset_n_i = 1'h1, forward_limit_i = 1'h0;
  logic reverse_limit_i = 1'h0, home_switch_i = 1'h0, homing_command_i = 1'h0, edge_search_i = 1'h0;
  logic find_index_i = 1'h0, begin_motion_i = 1'h0, latch_enable_i = 1'h0, latch_arm_i = 1'h0;
  logic m_run = 1'h0, m_fwd = 1'h1, l_run = 1'h0;
  logic [2:0] switch_polarity_select_i = 3'h7;
  logic amp_enable_o, internal_amp_off_o, step_pulse_pin_o, step_direction_pin_o, step_busy_o, error_n_o;
  logic motion_abort_o, program_abort_o, processor_reset_o, forward_blocked_o, reverse_blocked_o;
  logic limit_handler_routine_o, slew_o, decel_stop_o, home_defined_o, latch_armed_o, latch_captured_o;
  int fail_count = 0, checked = 0, n;
  always #5 clk_i = ~clk_i;
  maio_axis DUT (.*);
  maio_encoder_model u_menc (.clk_i(clk_i), .run_i(m_run), .fwd_i(m_fwd), .a_o(motor_encoder_a_i), .b_o(motor_encoder_b_i));
  maio_encoder_model u_lenc (.clk_i(clk_i), .run_i(l_run), .fwd_i(1'h1), .a_o(load_encoder_a_i), .b_o(load_encoder_b_i));
  // ==========
  // Shared tasks
  // ==========
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
  endtask
  function automatic logic [31:0] mag(input logic [31:0] v);
    return v[31] ? -v : v;
  endfunction
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========
  // Scenarios
  // ==========
  task automatic t_baud_cmd();
    check(baud_divisor_o, BAUD_DIV_FAST);
    baud_jumper_i = 1'h1;
    tick(3);
    check(baud_divisor_o, BAUD_DIV_SLOW);
    baud_jumper_i = 1'h0;
    check(motor_command_o, 16'h8000);
    motor_on_i = 1'h1;
    pulse(sample_tick_i);
    check(motor_command_o, 16'h1234);
    servo_result_i = 16'h5678;
    tick(3);
    check(motor_command_o, 16'h1234);
    $display("baud and command test done");
  endtask
  task automatic t_amp();
    check(amp_enable_o, 1'h1);
    abort_n_i = 1'h0;
    tick(3);
    check({amp_enable_o, motion_abort_o, program_abort_o}, 3'h3);
    abort_n_i = 1'h1;
    hardware_lockout_i = 1'h1;
    #1 check({amp_enable_o, internal_amp_off_o}, 2'h1);
    hardware_lockout_i = 1'h0;
    shutdown_on_error_i = 1'h1;
    commanded_pos_i = 32'h100;
    tick(3);
    check({error_n_o, amp_enable_o}, 2'h0);
    commanded_pos_i = 32'h10;
    tick(3);
    check({error_n_o, amp_enable_o}, 2'h3);
    commanded_pos_i = 32'h0;
    reset_n_i = 1'h0;
    tick(3);
    check(processor_reset_o, 1'h1);
    reset_n_i = 1'h1;
    tick(3);
    $display("amplifier test done");
  endtask
  task automatic t_step();
    for (int k = 0; k < 5; k++) begin
      l_run = k != 0;
      motor_type_setting_i = maio_mt_t'(k);
      step_active_high_i = k < 3;
      step_forward_i = k[0];
      tick(2);
      step_request_i = 1'h1;
      n = 0;
      repeat (12) begin
        tick(1);
        step_request_i = 1'h0;
        n += (step_pulse_pin_o === step_active_high_i);
        if (k == 1 || k == 2) d[k-1] = step_direction_pin_o;
      end
      check(n, (k == 0) ? 0 : 3);
      check(load_position_o, 32'h0);
    end
    check(d, 2'h1);
    motor_type_setting_i = MAIO_MT_SERVO;
    l_run = 1'h0;
    $display("step test done");
  endtask
  task automatic t_enc();
    m_run = 1'h1;
    l_run = 1'h1;
    tick(QUAD_MIN_CYC * 8);
    {m_run, l_run} = 2'h0;
    tick(4);
    check(mag(motor_position_o), 32'h8);
    check(mag(load_position_o), 32'h8);
    m_fwd = 1'h0;
    m_run = 1'h1;
    tick(QUAD_MIN_CYC * 8);
    m_run = 1'h0;
    m_fwd = 1'h1;
    tick(4);
    check(motor_position_o, 32'h0);
    encoder_pulse_dir_i = 1'h1;
    m_run = 1'h1;
    tick(QUAD_MIN_CYC * 8);
    m_run = 1'h0;
    tick(4);
    check(motor_position_o, 32'h2);
    encoder_pulse_dir_i = 1'h0;
    $display("encoder test done");
  endtask
  task automatic t_gpo();
    output_port_value_i = 4'ha;
    pulse(output_port_write_i);
    check(general_out_o, 4'ha);
    pulse(output_bit_set_i);
    check(general_out_o, 4'hb);
    output_bit_index_i = 2'h3;
    pulse(output_bit_clear_i);
    check(general_out_o, 4'h3);
    output_port_value_i = 4'h5;
    output_bit_set_i = 1'h1;
    pulse(output_port_write_i);
    output_bit_set_i = 1'h0;
    check(general_out_o, 4'h5);
    $display("output test done");
  endtask
  task automatic t_lim();
    forward_limit_i = 1'h1;
    n = 0;
    repeat (6) begin
      tick(1);
      n += limit_handler_routine_o;
    end
    check(n, 1);
    check({forward_blocked_o, reverse_blocked_o}, 2'h2);
    switch_polarity_select_i = 3'h6;
    tick(3);
    check(forward_blocked_o, 1'h0);
    forward_limit_i = 1'h0;
    reverse_limit_i = 1'h1;
    tick(3);
    check({forward_blocked_o, reverse_blocked_o}, 2'h3);
    reverse_limit_i = 1'h0;
    switch_polarity_select_i = 3'h7;
    tick(3);
    $display("limit test done");
  endtask
  task automatic t_latch();
    m_run = 1'h1;
    tick(QUAD_MIN_CYC * 8);
    m_run = 1'h0;
    tick(2);
    p = motor_position_o;
    latch_enable_i = 1'h1;
    pulse(latch_arm_i);
    check(latch_armed_o, 1'h1);
    general_in_i = 8'h01;
    tick(5);
    check({latch_captured_o, latch_armed_o, general_in_o}, {2'h2, 8'h01});
    check(latch_position_o, p);
    general_in_i = 8'h00;
    m_run = 1'h1;
    tick(QUAD_MIN_CYC * 8);
    m_run = 1'h0;
    general_in_i = 8'h01;
    tick(5);
    check(latch_position_o, p);
    general_in_i = 8'h00;
    $display("latch test done");
  endtask
  task automatic t_home();
    for (int j = 0; j < 2; j++) begin
      {homing_command_i, edge_search_i} = j ? 2'h1 : 2'h2;
      tick(1);
      {homing_command_i, edge_search_i} = 2'h0;
      pulse(begin_motion_i);
      check(slew_o, 1'h1);
      home_switch_i = ~home_switch_i;
      n = 0;
      repeat (8) begin
        tick(1);
        n += decel_stop_o;
      end
      check({n[1:0], slew_o}, 3'h2);
    end
    $display("homing test done");
  endtask
  // ==========
  // Main sequence and watchdog
  // ==========
  initial begin
    tick(2);
    nrst_i = 1'h1;
    tick(8);
    t_baud_cmd();
    t_amp();
    t_step();
    t_enc();
    t_gpo();
    t_lim();
    t_latch();
    t_home();
    close_out();
  end
  // The scenarios need well under a thousand cycles, so this only trips on a hang.
  initial begin
    tick(20000);
    fail_count++;
    close_out();
  end
endmodule
